// file: pkg/wsch_pkg.sv
// Constants, types and helpers shared by the welder serial command handler
package wsch_pkg;

  // ****************************************************************
  // Frame characters
  // ****************************************************************
  localparam logic [7:0] WSCH_CHAR_START = 8'h02;
  localparam logic [7:0] WSCH_CHAR_END = 8'h0d;
  localparam logic [7:0] WSCH_CHAR_ACK = 8'h06;
  localparam logic [7:0] WSCH_CHAR_NAK = 8'h15;
  localparam logic [7:0] WSCH_CHAR_ZERO = 8'h30;
  localparam logic [7:0] WSCH_CHAR_NINE = 8'h39;
  localparam logic [7:0] WSCH_CHAR_ONE = 8'h31;
  localparam logic [7:0] WSCH_CHAR_R = 8'h52;
  localparam logic [7:0] WSCH_CHAR_M = 8'h4d;
  localparam logic [7:0] WSCH_CHAR_DOLLAR = 8'h24;
  localparam logic [7:0] WSCH_CHAR_C = 8'h43;

  // ****************************************************************
  // Control methods
  // ****************************************************************
  localparam logic [2:0] WSCH_METHOD_SERIAL = 3'h2;

  // ****************************************************************
  // Register offsets, fields and reset values
  // ****************************************************************
  localparam logic [11:0] WSCH_OFS_CTRL = 12'h000;
  localparam logic [11:0] WSCH_OFS_RXCHAR = 12'h004;
  localparam logic [11:0] WSCH_OFS_TXCHAR = 12'h008;
  localparam logic [11:0] WSCH_OFS_STATUS = 12'h00c;
  localparam logic [11:0] WSCH_OFS_SHOTCNT = 12'h010;
  localparam logic [7:0] WSCH_RST_EQUIP = 8'h01;
  localparam int WSCH_TX_VALID_BIT = 8;
  localparam int WSCH_ST_EMIT_BIT = 0;
  localparam int WSCH_ST_ERR_BIT = 1;
  localparam int WSCH_ST_PEND_BIT = 2;
  localparam int WSCH_ST_LEFT_LSB = 4;
  localparam int WSCH_ST_METHOD_LSB = 8;

  // ****************************************************************
  // Reply layout
  // ****************************************************************
  localparam int WSCH_REPLY_MAX = 12;
  localparam logic [3:0] WSCH_LEN_STATUS = 4'hc;
  localparam logic [3:0] WSCH_LEN_ACK = 4'h5;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0]
  {
    WSCH_CMD_READ_SPLIT = 3'h0,
    WSCH_CMD_EMIT_START = 3'h1,
    WSCH_CMD_EMIT_STOP = 3'h2,
    WSCH_CMD_ERR_CLEAR = 3'h3,
    WSCH_CMD_SHOT_RESET = 3'h4
  } wsch_cmd_t;

  typedef enum logic [2:0]
  {
    WSCH_RX_IDLE = 3'b000,
    WSCH_RX_TENS = 3'b001,
    WSCH_RX_UNITS = 3'b011,
    WSCH_RX_CODE1 = 3'b010,
    WSCH_RX_CODE2 = 3'b110,
    WSCH_RX_TERM = 3'b111
  } wsch_rx_state_t;

  typedef struct packed
  {
    logic valid;
    wsch_cmd_t code;
  } wsch_command_t;

  typedef struct packed
  {
    logic [2:0] controlMethod;
    logic [3:0] schedTens;
    logic [3:0] schedUnits;
    logic [4:0] splitterFlags;
  } wsch_unit_status_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic wsch_is_digit(input logic [7:0] c);
    return (c >= WSCH_CHAR_ZERO) && (c <= WSCH_CHAR_NINE);
  endfunction

  function automatic logic [7:0] wsch_digit_char(input logic [3:0] d);
    return WSCH_CHAR_ZERO | {4'h0, d};
  endfunction

endpackage

// file: core/wsch_frame_parser.sv
// Receive-side frame parser: address match and command decode
`timescale 1ns/10ps
module wsch_frame_parser
  import wsch_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Own equipment number, decimal digits
  input wire logic [3:0] equipTens,
  input wire logic [3:0] equipUnits,
  // Incoming characters
  input wire logic charValid,
  input wire logic [7:0] charData,
  // Decoded command, one-cycle valid
  output wsch_command_t command
);

  wsch_rx_state_t state_r;
  wsch_rx_state_t state_nxt;
  logic [7:0] code1_r;
  wsch_command_t command_r;
  wsch_command_t command_nxt;
  logic codeKnown;
  wsch_cmd_t codeDecoded;

  assign command = command_r;

  // Two-character command decode; unknown codes are dropped silently
  always_comb
  begin
    codeKnown = 1'b1;
    codeDecoded = WSCH_CMD_READ_SPLIT;
    if (code1_r == WSCH_CHAR_R && charData == WSCH_CHAR_M)
      codeDecoded = WSCH_CMD_READ_SPLIT;
    else if (code1_r == WSCH_CHAR_DOLLAR && charData == WSCH_CHAR_ZERO)
      codeDecoded = WSCH_CMD_EMIT_START;
    else if (code1_r == WSCH_CHAR_DOLLAR && charData == WSCH_CHAR_NINE)
      codeDecoded = WSCH_CMD_EMIT_STOP;
    else if (code1_r == WSCH_CHAR_C && charData == WSCH_CHAR_ZERO)
      codeDecoded = WSCH_CMD_ERR_CLEAR;
    else if (code1_r == WSCH_CHAR_C && charData == WSCH_CHAR_ONE)
      codeDecoded = WSCH_CMD_SHOT_RESET;
    else
      codeKnown = 1'b0;
  end

  // Next state; a start character always restarts the frame
  always_comb
  begin
    state_nxt = state_r;
    if (charValid)
    begin
      if (charData == WSCH_CHAR_START)
        state_nxt = WSCH_RX_TENS;
      else
      begin
        unique case (state_r)
          WSCH_RX_IDLE: state_nxt = WSCH_RX_IDLE;
          WSCH_RX_TENS:
            state_nxt = (wsch_is_digit(charData) &&
              charData == wsch_digit_char(equipTens)) ?
              WSCH_RX_UNITS : WSCH_RX_IDLE;
          WSCH_RX_UNITS:
            state_nxt = (wsch_is_digit(charData) &&
              charData == wsch_digit_char(equipUnits)) ?
              WSCH_RX_CODE1 : WSCH_RX_IDLE;
          WSCH_RX_CODE1: state_nxt = WSCH_RX_CODE2;
          WSCH_RX_CODE2: state_nxt = codeKnown ? WSCH_RX_TERM : WSCH_RX_IDLE;
          WSCH_RX_TERM: state_nxt = WSCH_RX_IDLE;
          default: state_nxt = WSCH_RX_IDLE;
        endcase
      end
    end
  end

  // Command output fires only on the terminator of a good frame
  always_comb
  begin
    command_nxt = '{valid: 1'b0, code: command_r.code};
    if (charValid && charData == WSCH_CHAR_END && state_r == WSCH_RX_TERM)
      command_nxt.valid = 1'b1;
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (reset)
      state_r <= WSCH_RX_IDLE;
    else if (ce)
      state_r <= state_nxt;
  end

  // First code character, and the decoded code held for the terminator
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      code1_r <= 8'h00;
      command_r <= '{valid: 1'b0, code: WSCH_CMD_READ_SPLIT};
    end
    else if (ce)
    begin
      if (charValid && state_r == WSCH_RX_CODE1)
        code1_r <= charData;
      command_r <= command_nxt;
      if (charValid && state_r == WSCH_RX_CODE2 && codeKnown)
        command_r.code <= codeDecoded;
    end
  end

endmodule

// file: core/wsch_command_handler.sv
// Welder serial command handler: APB slave, reply builder and actions
//
// Function
// - Frames carry equipment number, tens then units.
// - Status reply carries schedule number as digits.
// - Status reply reports control method digit.
// - Status reply carries five splitter unit flags.
// - Emission-start command begins laser output.
// - Emission-stop command ends laser output.
// - Error-clear command drops error signal output.
// - Shot-reset command zeroes cumulative shot counter.
// - Actions only in serial mode, then acknowledge.
// - Other modes: do nothing, negative acknowledge.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
module wsch_command_handler
  import wsch_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int SHOT_W = 32
)
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Live unit state from the laser controller
  input wire wsch_unit_status_t unitStatus,
  input wire logic shotPulse,
  input wire logic errorEvent,
  // Laser controls
  output logic emissionOn,
  output logic errorSignal
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] equipDigits_r;
  logic [7:0] replyBuf_r [WSCH_REPLY_MAX];
  logic [3:0] txIdx_r;
  logic [3:0] txLen_r;
  logic replyPending;
  logic [3:0] txLeft;
  logic emissionOn_r;
  logic errorSignal_r;
  logic [SHOT_W-1:0] shotCount_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [31:0] readMux;
  logic readMapped;
  logic setupPhase;
  logic accessPhase;
  logic [11:0] regAddr;
  logic ctrlWrite;
  logic rxWrite;
  logic txPop;
  wsch_command_t command;
  logic methodSerial;
  logic actionGo;
  logic emitStart;
  logic emitStop;
  logic errClear;
  logic shotReset;

  // ****************************************************************
  // APB decode
  // ****************************************************************

  // Zero-wait slave; ce low stretches the access so nothing is lost
  assign pready = ce;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable && ce;
  assign regAddr = 12'(paddr);

  // Write strobes taken at the completing edge only
  assign ctrlWrite = accessPhase && pwrite && regAddr == WSCH_OFS_CTRL;
  // Characters offered while a reply waits are refused
  assign rxWrite = accessPhase && pwrite &&
    regAddr == WSCH_OFS_RXCHAR && !replyPending;
  // Reading the transmit register consumes one reply character
  assign txPop = accessPhase && !pwrite &&
    regAddr == WSCH_OFS_TXCHAR && replyPending;

  // Read multiplexer, also flags unmapped addresses
  always_comb
  begin
    readMux = 32'h0000_0000;
    readMapped = 1'b1;
    unique case (regAddr)
      WSCH_OFS_CTRL:
        readMux = {24'h00_0000, equipDigits_r};
      WSCH_OFS_RXCHAR:
        readMux = 32'h0000_0000;
      WSCH_OFS_TXCHAR:
      begin
        if (replyPending)
        begin
          readMux[7:0] = replyBuf_r[txIdx_r];
          readMux[WSCH_TX_VALID_BIT] = 1'b1;
        end
      end
      WSCH_OFS_STATUS:
      begin
        readMux[WSCH_ST_EMIT_BIT] = emissionOn_r;
        readMux[WSCH_ST_ERR_BIT] = errorSignal_r;
        readMux[WSCH_ST_PEND_BIT] = replyPending;
        readMux[WSCH_ST_LEFT_LSB +: 4] = txLeft;
        readMux[WSCH_ST_METHOD_LSB +: 3] = unitStatus.controlMethod;
      end
      WSCH_OFS_SHOTCNT:
        readMux = 32'(shotCount_r);
      default:
        readMapped = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle, stable in access
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (ce && setupPhase)
    begin
      prdata_r <= pwrite ? 32'h0000_0000 : readMux;
      pslverr_r <= !readMapped;
    end
  end

  // ****************************************************************
  // Configuration register
  // ****************************************************************

  // Own equipment number, tens digit in the upper nibble
  always_ff @(posedge mclk)
  begin
    if (reset)
      equipDigits_r <= WSCH_RST_EQUIP;
    else if (ce && ctrlWrite)
      equipDigits_r <= pwdata[7:0];
  end

  // ****************************************************************
  // Frame parser
  // ****************************************************************

  // Parser filters address and code; only complete frames come out
  wsch_frame_parser u_parser
  (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .equipTens(equipDigits_r[7:4]),
    .equipUnits(equipDigits_r[3:0]),
    .charValid(rxWrite),
    .charData(pwdata[7:0]),
    .command(command)
  );

  // ****************************************************************
  // Command execution
  // ****************************************************************

  // Actions are honoured only under serial control
  assign methodSerial = unitStatus.controlMethod == WSCH_METHOD_SERIAL;
  assign actionGo = command.valid && methodSerial;
  assign emitStart = actionGo && command.code == WSCH_CMD_EMIT_START;
  assign emitStop = actionGo && command.code == WSCH_CMD_EMIT_STOP;
  assign errClear = actionGo && command.code == WSCH_CMD_ERR_CLEAR;
  assign shotReset = actionGo && command.code == WSCH_CMD_SHOT_RESET;

  // Emission level, start sets and stop clears
  always_ff @(posedge mclk)
  begin
    if (reset)
      emissionOn_r <= 1'b0;
    else if (ce)
    begin
      if (emitStart)
        emissionOn_r <= 1'b1;
      else if (emitStop)
        emissionOn_r <= 1'b0;
    end
  end

  // Error signal; a new error in the clearing cycle wins
  always_ff @(posedge mclk)
  begin
    if (reset)
      errorSignal_r <= 1'b0;
    else if (ce)
    begin
      if (errorEvent)
        errorSignal_r <= 1'b1;
      else if (errClear)
        errorSignal_r <= 1'b0;
    end
  end

  // Shot total; a shot coinciding with the reset is still counted
  always_ff @(posedge mclk)
  begin
    if (reset)
      shotCount_r <= '0;
    else if (ce)
    begin
      if (shotReset)
        shotCount_r <= SHOT_W'(shotPulse);
      else
        shotCount_r <= shotCount_r + SHOT_W'(shotPulse);
    end
  end

  assign emissionOn = emissionOn_r;
  assign errorSignal = errorSignal_r;

  // ****************************************************************
  // Reply builder
  // ****************************************************************

  // Reply framing shared by all answers; data sampled at frame end
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < WSCH_REPLY_MAX; i++)
        replyBuf_r[i] <= 8'h00;
    end
    else if (ce && command.valid)
    begin
      replyBuf_r[0] <= WSCH_CHAR_START;
      replyBuf_r[1] <= wsch_digit_char(equipDigits_r[7:4]);
      replyBuf_r[2] <= wsch_digit_char(equipDigits_r[3:0]);
      if (command.code == WSCH_CMD_READ_SPLIT)
      begin
        replyBuf_r[3] <= wsch_digit_char(unitStatus.schedTens);
        replyBuf_r[4] <= wsch_digit_char(unitStatus.schedUnits);
        replyBuf_r[5] <=
          wsch_digit_char({1'b0, unitStatus.controlMethod});
        // Unit 1 first; each flag sent as a 0 or 1 character
        for (int i = 0; i < 5; i++)
          replyBuf_r[6 + i] <=
            wsch_digit_char({3'b000, unitStatus.splitterFlags[i]});
        replyBuf_r[11] <= WSCH_CHAR_END;
      end
      else
      begin
        replyBuf_r[3] <= methodSerial ? WSCH_CHAR_ACK : WSCH_CHAR_NAK;
        replyBuf_r[4] <= WSCH_CHAR_END;
      end
    end
  end

  // Reply read pointer and length
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      txIdx_r <= 4'h0;
      txLen_r <= 4'h0;
    end
    else if (ce)
    begin
      if (command.valid)
      begin
        txIdx_r <= 4'h0;
        txLen_r <= (command.code == WSCH_CMD_READ_SPLIT) ?
          WSCH_LEN_STATUS : WSCH_LEN_ACK;
      end
      else if (txPop)
        txIdx_r <= txIdx_r + 4'h1;
    end
  end

  // Pending while characters remain; blocks new frames meanwhile
  assign replyPending = txIdx_r != txLen_r;
  assign txLeft = txLen_r - txIdx_r;

endmodule

// file: tb/wsch_laser_model.sv
// Laser controller model: fires shots while emission is on
`timescale 1ns/10ps
module wsch_laser_model
  import wsch_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Firing request and beam state
  input wire logic fire,
  input wire logic emissionOn,
  // Shot pulses and their running total
  output logic shotPulse,
  output int shots
);
  logic [1:0] phase_r;
  // One shot every fourth cycle, never with the beam off
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      phase_r <= 2'h0;
      shotPulse <= 1'b0;
      shots <= 0;
    end
    else
    begin
      phase_r <= phase_r + 2'h1;
      shotPulse <= fire && emissionOn && phase_r == 2'h0;
      if (fire && emissionOn && phase_r == 2'h0)
        shots <= shots + 1;
    end
  end
endmodule

// file: tb/wsch_command_handler_assertions.sv
// Port checks for the welder serial command handler
`timescale 1ns/10ps
module wsch_command_handler_assertions
  import wsch_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int SHOT_W = 32
)
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Unit side
  input wire wsch_unit_status_t unitStatus,
  input wire logic shotPulse,
  input wire logic errorEvent,
  input wire logic emissionOn,
  input wire logic errorSignal
);
  // Frame end accepted; its action lands two edges later
  wire logic endWr = psel && penable && pwrite && ce && pwdata[7:0] ==
    WSCH_CHAR_END && paddr == ADDR_W'(WSCH_OFS_RXCHAR);
  wire logic setup = psel && !penable && ce;
  wire logic serial = unitStatus.controlMethod == WSCH_METHOD_SERIAL;
  wire logic inMap = paddr <= ADDR_W'(WSCH_OFS_SHOTCNT) && paddr[1:0] == 0;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_ready_is_ce: assert property (pready == ce)
    else $error("pready differs from ce");
  chk_emit_rise: assert property ($rose(emissionOn) |->
    $past(endWr, 2) && $past(serial)) else $error("emission rose unasked");
  chk_emit_fall: assert property ($fell(emissionOn) |->
    $past(reset) || ($past(endWr, 2) && $past(serial)))
    else $error("emission fell unasked");
  chk_err_set: assert property (errorEvent && ce |=> errorSignal)
    else $error("error output not set");
  chk_err_clear: assert property ($fell(errorSignal) |->
    $past(reset) || ($past(endWr, 2) && $past(serial)))
    else $error("error output cleared unasked");
  chk_err_cause: assert property ($rose(errorSignal) |->
    $past(errorEvent)) else $error("error output rose unasked");
  chk_ce_freeze: assert property (!ce |=> $stable(emissionOn) &&
    $stable(errorSignal)) else $error("state moved with ce low");
  chk_bad_addr: assert property (setup && paddr >
    ADDR_W'(WSCH_OFS_SHOTCNT) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_good_addr: assert property (setup && inMap |=> !pslverr)
    else $error("mapped access refused");
  chk_status_bits: assert property (setup && !pwrite &&
    paddr == ADDR_W'(WSCH_OFS_STATUS) |=>
    prdata[1:0] == $past({errorSignal, emissionOn}))
    else $error("status bits wrong");

  // Main scenarios reached
  cov_emit: cover property ($rose(emissionOn));
  cov_clear: cover property ($fell(errorSignal));
  cov_refuse: cover property (pslverr);
endmodule

bind wsch_command_handler wsch_command_handler_assertions #(
  .ADDR_W(ADDR_W), .SHOT_W(SHOT_W)) chkInst (.mclk(mclk),
  .reset(reset), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .unitStatus(unitStatus),
  .shotPulse(shotPulse), .errorEvent(errorEvent),
  .emissionOn(emissionOn), .errorSignal(errorSignal));

// file: tb/wsch_command_handler_tb.sv
// Self-checking bench for the welder serial command handler
`timescale 1ns/10ps
module wsch_command_handler_tb
  import wsch_pkg::*;
;
  // ********************
  // Signals and model
  // ********************
  logic mclk, reset, ce, psel, penable, pwrite, pready, pslverr, err;
  logic shotPulse, errorEvent, emissionOn, errorSignal, fire;
  logic expEmit, expErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] expQ[$], gotQ[$];
  logic [3:0] eqT, eqU;
  logic [15:0] codes[4] = '{16'h4330, 16'h4331, 16'h2439, 16'h2430};
  logic [2:0] modes[7] = '{0, 1, 2, 3, 4, 5, 2};
  wsch_unit_status_t unitStatus;
  int mismatches, checked, shots, shotBase;

  wsch_command_handler DUT (.mclk(mclk), .reset(reset), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .unitStatus(unitStatus), .shotPulse(shotPulse),
    .errorEvent(errorEvent), .emissionOn(emissionOn),
    .errorSignal(errorSignal));
  wsch_laser_model laser (.mclk(mclk), .reset(reset), .fire(fire),
    .emissionOn(emissionOn), .shotPulse(shotPulse), .shots(shots));

  // 50 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ********************
  // Tasks
  // ********************
  function automatic logic [7:0] dig(input logic [3:0] d);
    return 8'h30 + {4'h0, d};
  endfunction

  task automatic chkWord(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkReply(input string what);
    checked++;
    if (gotQ.size() != expQ.size())
    begin
      mismatches++;
      $display("MISMATCH %s expected %0d chars seen %0d", what,
        expQ.size(), gotQ.size());
    end
    else
      foreach (expQ[i])
        chkWord(what, {24'h0, expQ[i]}, {24'h0, gotQ[i]});
  endtask

  // One APB transfer, held until pready; one idle cycle after
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // Wait states end only on pready; the watchdog bounds a hang
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Send a frame, then poll the reply until it runs dry
  task automatic frame(input logic [3:0] t, u, input logic [15:0] c);
    logic [7:0] ch[6];
    ch = '{WSCH_CHAR_START, dig(t), dig(u), c[15:8], c[7:0], WSCH_CHAR_END};
    foreach (ch[i])
      apb(1'b1, WSCH_OFS_RXCHAR, {24'h0, ch[i]});
    gotQ.delete();
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b0, WSCH_OFS_TXCHAR, 32'h0);
      if (rd[8] === 1'b1)
        gotQ.push_back(rd[7:0]);
      else if (gotQ.size() != 0 || i > 3)
        break;
    end
  endtask

  task automatic chkState(input logic [2:0] m);
    apb(1'b0, WSCH_OFS_STATUS, 32'h0);
    chkWord("status", {21'h0, m, 6'h0, expErr, expEmit}, rd);
    apb(1'b0, WSCH_OFS_SHOTCNT, 32'h0);
    chkWord("cumulative_pulse_counter", 32'(shots - shotBase), rd);
    chkWord("pins", {30'h0, expErr, expEmit}, {30'h0, errorSignal, emissionOn});
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the tests need about 1800 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    conclude();
  end

  // ********************
  // Tests
  // ********************
  initial
  begin
    {reset, ce, psel, penable, pwrite, errorEvent, fire} = 7'h60;
    paddr = 12'h0;
    pwdata = 32'h0;
    unitStatus = '0;
    {mismatches, checked, shotBase} = '0;
    {expEmit, expErr} = 2'b00;
    void'($urandom(32'hf8a7));
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    apb(1'b0, WSCH_OFS_CTRL, 32'h0);
    chkWord("ctrl reset", 32'h1, rd);
    chkState(3'h0);
    apb(1'b0, WSCH_OFS_RXCHAR, 32'h0);
    chkWord("rx read", 32'h0, rd);
    apb(1'b0, 12'h014, 32'h0);
    chkWord("unmapped", 32'h1, {31'h0, err});
    $display("test reset values done");
    eqT = 4'($urandom_range(9));
    eqU = 4'($urandom_range(9));
    apb(1'b1, WSCH_OFS_CTRL, {24'h0, eqT, eqU});
    // Status reads in control methods 0 to 5, random unit state
    for (int i = 0; i < 6; i++)
    begin
      unitStatus <= {3'(i), 4'($urandom_range(9)), 4'($urandom_range(9)),
        5'($urandom)};
      @(posedge mclk);
      expQ = '{WSCH_CHAR_START, dig(eqT), dig(eqU),
        dig(unitStatus.schedTens), dig(unitStatus.schedUnits),
        dig({1'b0, unitStatus.controlMethod})};
      for (int j = 0; j < 5; j++)
        expQ.push_back(dig({3'h0, unitStatus.splitterFlags[j]}));
      expQ.push_back(WSCH_CHAR_END);
      frame(eqT, eqU, 16'h524d);
      chkReply("status reply");
    end
    $display("test status reply done");
    // Every action in control methods 0 to 5; serial mode visited twice
    foreach (modes[k])
    begin
      unitStatus.controlMethod <= modes[k];
      errorEvent <= 1'b1;
      @(posedge mclk);
      errorEvent <= 1'b0;
      expErr = 1'b1;
      @(posedge mclk);
      foreach (codes[j])
      begin
        frame(eqT, eqU, codes[j]);
        expQ = '{WSCH_CHAR_START, dig(eqT), dig(eqU), modes[k] == 3'h2 ?
          WSCH_CHAR_ACK : WSCH_CHAR_NAK, WSCH_CHAR_END};
        if (modes[k] == 3'h2)
          case (codes[j])
            16'h4330: expErr = 1'b0;
            16'h4331: shotBase = shots;
            16'h2439: expEmit = 1'b0;
            default: expEmit = 1'b1;
          endcase
        chkReply("action reply");
        chkState(modes[k]);
      end
      fire <= 1'b1;
      repeat (16) @(posedge mclk);
      fire <= 1'b0;
      repeat (3) @(posedge mclk);
      chkState(modes[k]);
    end
    $display("test actions done");
    frame(eqT ^ 4'h1, eqU, 16'h2439);
    expQ.delete();
    chkReply("foreign reply");
    // Own number but a code the block does not know: no answer
    frame(eqT, eqU, 16'h2435);
    chkReply("unknown reply");
    chkState(3'h2);
    $display("test foreign frame done");
    // Stall the access phase with ce low
    fork
      apb(1'b0, WSCH_OFS_CTRL, 32'h0);
      begin
        @(posedge mclk);
        ce <= 1'b0;
        repeat (3) @(posedge mclk);
        ce <= 1'b1;
      end
    join
    chkWord("ctrl stalled", {24'h0, eqT, eqU}, rd);
    $display("test stall done");
    conclude();
  end
endmodule
